//--- flash_bus_pin_interface_test.sv
// testbench for the flash pin interface with a host controller model
// assumes: design and package compiled first; clk 50 ns, link clock 125 ns
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_cfg.svh"
module flash_bus_pin_interface_test;
  import flash_pin_pkg::*;
  localparam logic [24:0] ADDR_LO = 25'h0000005;
  localparam logic [24:0] ADDR_HI = 25'h1000005;
  logic          clk, rst_n, link_raw, link_clk, host_oe, dq_oe, wait_oe, wait_out;
  logic          rd_stb, w_last, pol, wait_wire, ce;
  logic [15:0]   host_dq, dq_out, dq_last, dq_wire, d0, d1;
  logic [24:0]   addr_pin;
  logic [16:0]   rd_data;
  ctrl_pins_type ctrl;
  int            wait_seen, num_errors, total_checks;
  logic [16:0]   exp_q[$];
  // ---------------------------------------------
  // clocks, bus resolution, instances
  // ---------------------------------------------
  always #25 clk = ~clk;
  always #62.5 link_raw = ~link_raw;
  // a released line shows the inverse of its last driven level
  assign dq_wire   = dq_oe ? dq_out : (host_oe ? host_dq : ~dq_last);
  assign wait_wire = wait_oe ? wait_out : ~w_last;
  always @(posedge clk)
  begin
    if (dq_oe || host_oe)
      dq_last <= dq_wire;
    if (wait_oe)
      w_last <= wait_out;
  end
  flash_pin_if dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .ctrl(ctrl),
    .addr_pin(addr_pin), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe(dq_oe),
    .wait_out(wait_out), .wait_oe(wait_oe));
  flash_host_model host_u (.clk(clk), .link_raw(link_raw), .link_clk(link_clk), .ctrl(ctrl),
    .addr_pin(addr_pin), .host_dq(host_dq), .host_oe(host_oe), .dq_wire(dq_wire),
    .wait_wire(wait_wire), .rd_data(rd_data), .rd_stb(rd_stb), .wait_seen(wait_seen));
  // ---------------------------------------------
  // checking
  // ---------------------------------------------
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge rd_stb)
    check(rd_data, exp_q.pop_front());
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic rd(input logic [24:0] a, input logic [24:0] a2, input logic l, input logic [15:0] d);
    exp_q.push_back({~pol, d});
    host_u.read_async(a, a2, l);
  endtask : rd
  task automatic cmd(input logic [24:0] a, input logic [7:0] c, input logic [15:0] d);
    host_u.write_word(a, {8'h00, c});
    host_u.write_word(a, d);
  endtask : cmd
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  initial
  begin
    #(20000 * 50);
    num_errors++;
    finish_test();
  end
  initial
  begin
    clk          = 1'b0;
    link_raw     = 1'b0;
    rst_n        = 1'b0;
    ce           = 1'b1;
    pol          = 1'b0;
    dq_last      = '0;
    w_last       = 1'b0;
    num_errors   = 0;
    total_checks = 0;
    void'($urandom(32'h4e1d));
    d0 = 16'($urandom());
    d1 = 16'($urandom());
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    host_u.set_aux(1'b1, 1'b0);
    for (int i = 1; i < 4; i++)
    begin
      host_u.pins(i[0], i[1], 1'b1, 1'b1);
      host_u.step(4);
      check({15'h0, dq_oe, wait_oe}, 17'h0);
    end
    host_u.pins(1'b1, 1'b1, 1'b1, 1'b1);
    host_u.write_word(ADDR_LO, 16'h0070);
    rd(ADDR_LO, ADDR_LO, 1'b1, 16'h0080);
    cmd(ADDR_LO, 8'h40, d0);
    host_u.write_word(ADDR_LO, 16'h0070);
    rd(ADDR_LO, ADDR_LO, 1'b1, 16'h0082);
    host_u.write_word(ADDR_LO, 16'h0050);
    cmd(ADDR_LO, 8'h60, 16'h002f);
    cmd(ADDR_LO, 8'h60, 16'h00d0);
    host_u.write_word(ADDR_LO, 16'h0070);
    rd(ADDR_LO, ADDR_LO, 1'b1, 16'h0082);
    host_u.write_word(ADDR_LO, 16'h0050);
    host_u.set_aux(1'b1, 1'b1);
    cmd(ADDR_LO, 8'h60, 16'h00d0);
    cmd(ADDR_HI, 8'h60, 16'h00d0);
    cmd(ADDR_LO, 8'h40, d0);
    cmd(ADDR_HI, 8'h40, d1);
    host_u.write_word(ADDR_LO, 16'h00ff);
    rd(ADDR_LO, ADDR_LO, 1'b1, d0);
    rd(ADDR_HI, ADDR_HI, 1'b1, d1);
    rd(ADDR_LO, ADDR_HI, 1'b1, d0);
    rd(ADDR_LO, ADDR_HI, 1'b0, d1);
    // a write made while the enable is low must leave no trace
    ce = 1'b0;
    host_u.write_word(ADDR_LO, 16'h0070);
    ce = 1'b1;
    rd(ADDR_LO, ADDR_LO, 1'b1, d0);
    for (int p = 1; p >= 0; p--)
    begin
      pol = p[0];
      cmd(25'({p[0], 10'h000}), 8'h60, 16'h0003);
      host_u.write_word(ADDR_LO, 16'h00ff);
      exp_q.push_back({~pol, d1});
      host_u.read_sync(ADDR_HI, pol);
      check(17'(wait_seen > 0 && wait_seen < 9), 17'h1);
    end
    pol = 1'b0;
    host_u.write_word(ADDR_LO, 16'h0070);
    host_u.set_aux(1'b0, 1'b1);
    host_u.write_word(ADDR_LO, 16'h0070);
    host_u.set_aux(1'b1, 1'b1);
    rd(ADDR_HI, ADDR_HI, 1'b1, d1);
    host_u.write_word(ADDR_LO, 16'h0070);
    rd(ADDR_LO, ADDR_LO, 1'b1, 16'h0080);
    host_u.step(4);
    finish_test();
  end
endmodule : flash_bus_pin_interface_test
`default_nettype wire

//--- flash_host_model.sv
// host controller model: drives the flash pins as a bus master would
// assumes: clk is the core clock; link_raw runs free and is gated to frames here
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // clocks
  input  wire  logic                   clk,
  input  wire  logic                   link_raw,
  output logic                         link_clk,
  // pins toward the device
  output flash_pin_pkg::ctrl_pins_type ctrl,
  output logic [24:0]                  addr_pin,
  output logic [15:0]                  host_dq,
  output logic                         host_oe,
  // resolved bus levels and results
  input  wire  logic [15:0]            dq_wire,
  input  wire  logic                   wait_wire,
  output logic [16:0]                  rd_data,
  output logic                         rd_stb,
  output int                           wait_seen
);
  import flash_pin_pkg::*;
  logic frame;
  // link clock stands still outside a sync read frame
  assign link_clk = link_raw & frame;
  initial
  begin
    frame     = 1'b0;
    rd_stb    = 1'b0;
    rd_data   = '0;
    wait_seen = 0;
    addr_pin  = '0;
    host_dq   = '0;
    host_oe   = 1'b0;
    ctrl      = '1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic pins(input logic sel, input logic oe, input logic we, input logic adv);
    ctrl.flash_select_n        = sel;
    ctrl.flash_output_enable_n = oe;
    ctrl.write_enable_n        = we;
    ctrl.address_valid_n       = adv;
  endtask : pins
  task automatic set_aux(input logic rst, input logic wp);
    ctrl.reset_n         = rst;
    ctrl.write_protect_n = wp;
    step(4);
  endtask : set_aux
  // write enable rises first; data then changes while select is still low
  task automatic write_word(input logic [24:0] a, input logic [15:0] d);
    step(1);
    addr_pin = a;
    host_dq  = d;
    host_oe  = 1'b1;
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    step(4);
    ctrl.write_enable_n = 1'b1;
    step(4);
    host_dq = ~d;
    step(4);
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    step(4);
    host_oe = 1'b0;
  endtask : write_word
  task automatic finish_read();
    rd_data = {wait_wire, dq_wire};
    rd_stb  = 1'b1;
    step(1);
    rd_stb = 1'b0;
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    step(4);
  endtask : finish_read
  // address moves to a2 after the strobe rises (latch) or stays low (flow)
  task automatic read_async(input logic [24:0] a, input logic [24:0] a2, input logic latch);
    step(1);
    addr_pin = a;
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    step(4);
    ctrl.address_valid_n = latch;
    step(4);
    addr_pin = a2;
    step(5);
    finish_read();
  endtask : read_async
  // three link edges per frame: two with the strobe high re-arm the link side
  // and let its enable settle, the third takes the address with the strobe low
  task automatic read_sync(input logic [24:0] a, input logic p);
    step(1);
    addr_pin = a;
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    step(4);
    @(negedge link_raw);
    frame = 1'b1;
    repeat (2) @(negedge link_raw);
    step(1);
    ctrl.address_valid_n = 1'b0;
    @(negedge link_raw);
    frame     = 1'b0;
    wait_seen = 0;
    repeat (20)
    begin
      step(1);
      if (wait_wire === p)
        wait_seen++;
    end
    finish_read();
  endtask : read_sync
endmodule : flash_host_model
`default_nettype wire

//--- flash_pin_cfg.svh
// flash pin interface: command codes, field positions, reset values, timing counts
// assumes: included by its bare name, definitions only
`ifndef FLASH_PIN_CFG_SVH
`define FLASH_PIN_CFG_SVH
// ---------------------------------------------
// reset values and field positions
// ---------------------------------------------
`define STATUS_RESET        8'h80
`define CFG_RESET           16'h8000
`define CFG_ASYNC_BIT       15
`define CFG_WAIT_POL_BIT    10
`define STATUS_LOCK_ERR_BIT 1
// ---------------------------------------------
// command codes
// ---------------------------------------------
`define CMD_READ_ARRAY      8'hff
`define CMD_READ_STATUS     8'h70
`define CMD_READ_CONFIG     8'h90
`define CMD_CLEAR_STATUS    8'h50
`define CMD_PROGRAM         8'h40
`define CMD_LOCK_SETUP      8'h60
`define CMD_LOCK            8'h01
`define CMD_UNLOCK          8'hd0
`define CMD_LOCKDOWN        8'h2f
`define CMD_CFG_SET         8'h03
// ---------------------------------------------
// timing
// ---------------------------------------------
`define CLK_MHZ             20
`define WAIT_LATENCY_NS     100
`define WAIT_CYCLES         ((`WAIT_LATENCY_NS * `CLK_MHZ + 999) / 1000)
`endif

//--- flash_pin_if.sv
// flash pin interface: device-side bus pins of a dual-die 16-bit flash
// assumes: host pins are asynchronous to clk; link_clk is the host burst clock
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_cfg.svh"
module flash_pin_if #(
  parameter int ADDR_W   = 25,
  parameter int ADDR_LSB = 0,
  parameter bit DUAL_DIE = 1'b1,
  parameter int IDX_W    = 6,
  parameter int BLK_W    = 2
) (
  // system clock domain
  input  wire  logic                          clk,
  input  wire  logic                          rst_n,
  input  wire  logic                          ce,
  // host burst clock
  input  wire  logic                          link_clk,
  // host control pins
  input  wire  flash_pin_pkg::ctrl_pins_type  ctrl,
  input  wire  logic [ADDR_LSB+ADDR_W-1:ADDR_LSB] addr_pin,
  // data bus and ready indicator
  input  wire  logic [15:0]                   dq_in,
  output logic       [15:0]                   dq_out,
  output logic                                dq_oe,
  output logic                                wait_out,
  output logic                                wait_oe
);
  import flash_pin_pkg::*;

  localparam int PW = 6 + ADDR_W + 16;
  localparam int MW = 2 ** (IDX_W + 1);
  localparam int NB = 2 ** (BLK_W + 1);
  localparam int WAIT_CYCLES = `WAIT_CYCLES;
  localparam int CW = $clog2(WAIT_CYCLES + 1);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    logic [PW-1:0]        meta;
    logic [PW-1:0]        sync;
    ctrl_pins_type        prev;
    logic [2:0]           tgl;
    logic [ADDR_W-1:0]    addr_q;
    logic                 held;
    logic                 in_write;
    logic [ADDR_W-1:0]    wr_a;
    logic [15:0]          wr_d;
    logic [MW-1:0][15:0]  mem;
    logic [NB-1:0]        lock;
    logic [NB-1:0]        lockdn;
    logic [15:0]          cfg;
    logic [7:0]           status;
    read_mode_type        mode;
    cmd_phase_type        phase;
    logic [CW-1:0]        wait_cnt;
    logic [15:0]          dout;
  } core_type;

  typedef struct packed {
    logic [1:0]           ce_s;
    logic                 tgl;
    logic                 armed;
    logic [ADDR_W-1:0]    cap;
  } link_type;

  // toggle history matches the link side's reset value: no false event after reset
  localparam core_type CORE_RST = '{lockdn: '0, in_write: 1'b0, wait_cnt: '0, tgl: '0,
    dout: '0, cfg: `CFG_RESET, status: `STATUS_RESET, mode: MODE_ARRAY,
    phase: PH_IDLE, default: '1};

  core_type            c_q;
  core_type            c_d;
  link_type            l_q;
  link_type            l_d;
  ctrl_pins_type       p;
  logic [ADDR_W-1:0]   wa;
  logic [ADDR_W-1:0]   link_addr;
  logic [15:0]         din;
  logic                sync_mode;
  logic                reading;
  logic                link_evt;
  logic                adv_fall;
  logic                adv_rise;
  logic                wr_evt;
  logic                wait_asserted;
  logic [BLK_W:0]      wbk;

  // ---------------------------------------------
  // decode helpers
  // ---------------------------------------------
  function automatic logic die_of(input logic [ADDR_W-1:0] a);
    return DUAL_DIE ? a[ADDR_W-1] : 1'b0;
  endfunction : die_of

  function automatic logic [IDX_W:0] word_of(input logic [ADDR_W-1:0] a);
    return {die_of(a), a[IDX_W-1:0]};
  endfunction : word_of

  function automatic logic [BLK_W:0] block_of(input logic [ADDR_W-1:0] a);
    return {die_of(a), a[IDX_W-1 -: BLK_W]};
  endfunction : block_of

  // pin numbering may start at one; internally bit zero is the lowest word bit
  assign link_addr = addr_pin;
  assign p         = ctrl_pins_type'(c_q.sync[PW-1 -: 6]);
  assign wa        = c_q.sync[16 +: ADDR_W];
  assign din       = c_q.sync[15:0];
  assign sync_mode = !c_q.cfg[`CFG_ASYNC_BIT];
  assign reading   = !p.flash_select_n && !p.flash_output_enable_n
                     && p.write_enable_n && p.reset_n;
  assign link_evt  = c_q.tgl[1] ^ c_q.tgl[2];
  assign adv_fall  = c_q.prev.address_valid_n && !p.address_valid_n;
  assign adv_rise  = !c_q.prev.address_valid_n && p.address_valid_n;
  assign wr_evt    = c_q.in_write && (p.flash_select_n || p.write_enable_n)
                     && p.reset_n;
  assign wbk       = block_of(c_q.wr_a);

  // ---------------------------------------------
  // link side: capture on a burst clock edge
  // ---------------------------------------------
  always_comb
  begin
    l_d = l_q;
    l_d.ce_s = {l_q.ce_s[0], ce};
    if (l_q.ce_s[1])
    begin
      if (ctrl.address_valid_n)
        l_d.armed = 1'b0;
      else if (!l_q.armed && !ctrl.flash_select_n)
      begin
        l_d.cap   = link_addr;
        l_d.tgl   = !l_q.tgl;
        l_d.armed = 1'b1;
      end
    end
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  // ---------------------------------------------
  // core side
  // ---------------------------------------------
  // cap is read only after its toggle has crossed; the host must not start a
  // new address phase before the previous one has been taken
  always_comb
  begin
    c_d = c_q;
    c_d.meta = {ctrl, addr_pin, dq_in};
    c_d.sync = c_q.meta;
    c_d.tgl  = {c_q.tgl[1], c_q.tgl[0], l_q.tgl};
    c_d.prev = p;
    if (c_q.wait_cnt != '0)
      c_d.wait_cnt = c_q.wait_cnt - CW'(1);
    // address latch
    if (adv_fall)
      c_d.held = 1'b0;
    if (!sync_mode && !p.address_valid_n && !c_d.held)
      c_d.addr_q = wa;
    if (adv_rise && !c_d.held)
    begin
      c_d.addr_q   = wa;
      c_d.held     = 1'b1;
      c_d.wait_cnt = CW'(WAIT_CYCLES);
    end
    else if (sync_mode && link_evt && !c_d.held)
    begin
      c_d.addr_q   = l_q.cap;
      c_d.held     = 1'b1;
      c_d.wait_cnt = CW'(WAIT_CYCLES);
    end
    // write cycle: track while low, take the word at the first rising strobe
    if (!p.flash_select_n && !p.write_enable_n)
    begin
      c_d.in_write = 1'b1;
      c_d.wr_a     = wa;
      c_d.wr_d     = din;
    end
    if (wr_evt)
    begin
      c_d.in_write = 1'b0;
      case (c_q.phase)
        PH_PROG:
        begin
          if (c_q.lock[wbk])
            c_d.status[`STATUS_LOCK_ERR_BIT] = 1'b1;
          else
            c_d.mem[word_of(c_q.wr_a)] = c_q.wr_d;
          c_d.mode  = MODE_STATUS;
          c_d.phase = PH_IDLE;
        end
        PH_LOCKSET:
        begin
          if (c_q.wr_d[7:0] == `CMD_LOCK)
            c_d.lock[wbk] = 1'b1;
          else if (c_q.wr_d[7:0] == `CMD_LOCKDOWN)
          begin
            c_d.lock[wbk]   = 1'b1;
            c_d.lockdn[wbk] = 1'b1;
          end
          else if (c_q.wr_d[7:0] == `CMD_UNLOCK)
          begin
            if (c_q.lockdn[wbk] && !p.write_protect_n)
              c_d.status[`STATUS_LOCK_ERR_BIT] = 1'b1;
            else
              c_d.lock[wbk] = 1'b0;
          end
          else if (c_q.wr_d[7:0] == `CMD_CFG_SET)
            c_d.cfg = c_q.wr_a[15:0];
          c_d.phase = PH_IDLE;
        end
        default:
        begin
          case (c_q.wr_d[7:0])
            `CMD_READ_ARRAY:   c_d.mode = MODE_ARRAY;
            `CMD_READ_STATUS:  c_d.mode = MODE_STATUS;
            `CMD_READ_CONFIG:  c_d.mode = MODE_CONFIG;
            `CMD_CLEAR_STATUS: c_d.status = `STATUS_RESET;
            `CMD_PROGRAM:      c_d.phase = PH_PROG;
            `CMD_LOCK_SETUP:   c_d.phase = PH_LOCKSET;
            default:           c_d.phase = PH_IDLE;
          endcase
        end
      endcase
    end
    // reset pin: automation back to idle, writes dropped, array kept
    if (!p.reset_n)
    begin
      c_d.in_write = 1'b0;
      c_d.phase    = PH_IDLE;
      c_d.mode     = MODE_ARRAY;
      c_d.cfg      = `CFG_RESET;
      c_d.status   = `STATUS_RESET;
      c_d.lock     = '1;
      c_d.lockdn   = '0;
      c_d.held     = 1'b0;
      c_d.wait_cnt = '0;
    end
    // output word
    case (c_d.mode)
      MODE_STATUS: c_d.dout = {8'h00, c_d.status};
      MODE_CONFIG: c_d.dout = c_d.cfg;
      default:     c_d.dout = c_d.mem[word_of(c_d.addr_q)];
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      c_q <= CORE_RST;
    else if (ce)
      c_q <= c_d;
  end

  // ---------------------------------------------
  // pin drivers
  // ---------------------------------------------
  // async page reads and writes never assert; invalid until latency expires
  assign wait_asserted = sync_mode && reading
                         && (!c_q.held || c_q.wait_cnt != '0);
  assign wait_out = wait_asserted ? c_q.cfg[`CFG_WAIT_POL_BIT]
                                  : !c_q.cfg[`CFG_WAIT_POL_BIT];
  assign wait_oe  = !p.flash_select_n && !p.flash_output_enable_n
                    && p.reset_n;
  assign dq_oe    = reading;
  assign dq_out   = c_q.dout;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_deselect_float: assert property (@(posedge clk) disable iff (!rst_n)
    p.flash_select_n |-> (!dq_oe && !wait_oe))
    else $error("outputs driven while deselected");

  a_oe_float: assert property (@(posedge clk) disable iff (!rst_n)
    p.flash_output_enable_n |-> (!dq_oe && !wait_oe))
    else $error("outputs driven with output enable high");

  a_wait_drive: assert property (@(posedge clk) disable iff (!rst_n)
    wait_oe |-> (!p.flash_select_n && !p.flash_output_enable_n))
    else $error("ready driven outside select and output enable");

  a_wait_async: assert property (@(posedge clk) disable iff (!rst_n)
    (!sync_mode || !p.write_enable_n)
      |-> (wait_out == !c_q.cfg[`CFG_WAIT_POL_BIT]))
    else $error("ready asserted in async read or write");

  a_wait_latency: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && sync_mode && reading && $rose(c_q.held))
      |-> (c_q.wait_cnt == CW'(WAIT_CYCLES))
          && (wait_out == c_q.cfg[`CFG_WAIT_POL_BIT]))
    else $error("ready not asserted for the read latency");

  a_reset_write: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !p.reset_n) |=> (!c_q.in_write && c_q.phase == PH_IDLE))
    else $error("write accepted during reset");

  a_reset_state: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !p.reset_n) |=> (c_q.status == `STATUS_RESET
      && c_q.cfg[`CFG_ASYNC_BIT] && c_q.mode == MODE_ARRAY))
    else $error("reset state not restored");

  a_lockdown_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_evt && c_q.phase == PH_LOCKSET && c_q.wr_d[7:0] == `CMD_UNLOCK
      && c_q.lockdn[wbk] && !p.write_protect_n && p.reset_n)
      |=> c_q.lock[$past(wbk)])
    else $error("locked-down block unlocked under write protect");

  a_addr_flow: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !sync_mode && !p.address_valid_n && !c_q.held && p.reset_n)
      |=> (c_q.addr_q == $past(wa)))
    else $error("address does not flow through in async mode");
endmodule : flash_pin_if
`default_nettype wire

//--- flash_pin_pkg.sv
// flash pin interface: shared types
// assumes: nothing beyond the compile order
package flash_pin_pkg;
  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_CONFIG} read_mode_type;
  typedef enum logic [1:0] {PH_IDLE, PH_PROG, PH_LOCKSET} cmd_phase_type;
  typedef struct packed {
    logic flash_select_n;
    logic flash_output_enable_n;
    logic write_enable_n;
    logic address_valid_n;
    logic reset_n;
    logic write_protect_n;
  } ctrl_pins_type;
endpackage : flash_pin_pkg
